// File: bench/eil_pin_model.sv
// Model of the external device driving the interrupt pin
`timescale 1ns/1ps
module eil_pin_model (
   // Clock and control
   input  wire logic sys_clk_i,
   input  wire logic hold_low_i,
   // Pin, idle high
   output logic      ext_int_n_o
);
   initial ext_int_n_o = 1'b1;
   always @(posedge sys_clk_i) begin
      ext_int_n_o <= !hold_low_i;
   end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, low = 1'b0;
   logic        vf = 1'b0, condition_code_register = 1'b0, brk = 1'b0, bce = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wd = 8'h00, rdat;
   logic        pin_n, irq, wake, lvl;
   logic [15:0] vhi, vlo;
   int          errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   eil_pin_model i_eil_pin_model (.sys_clk_i(clk), .hold_low_i(low), .ext_int_n_o(pin_n));
   eil_latch i_eil_latch (.sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .ext_int_n_i(pin_n), .vector_fetch_i(vf), .ccr_int_mask_i(condition_code_register),
      .break_state_i(brk), .break_clear_enable_i(bce), .int_request_o(irq),
      .wake_request_o(wake), .vector_addr_hi_o(vhi), .vector_addr_lo_o(vlo),
      .pin_level_o(lvl));
   task complete_run;
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("reg_rdata", {8'h00, e}, {8'h00, rdat});
   endtask
   task pin(input logic l);
      @(posedge clk);
      low <= l;
      cyc(6);
   endtask
   task t_reset;
      rd_chk(4'h0, 8'h00);
      chk("vector_hi", 16'hfffa, vhi);
      chk("vector_lo", 16'hfffb, vlo);
      wr_reg(4'h5, 8'h03);
      rd_chk(4'h5, 8'h00);
      rd_chk(4'h0, 8'h00);
      pin(1'b1);
      pin(1'b0);
      chk("int_request", 16'h1, {15'h0, irq});
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(4'h0, 8'h00);
      chk("int_request", 16'h0, {15'h0, irq});
   endtask
   task t_edge;
      pin(1'b1);
      chk("int_request", 16'h1, {15'h0, irq});
      chk("pin_level", 16'h0, {15'h0, lvl});
      rd_chk(4'h0, 8'h08);
      wr_reg(4'h0, 8'h04);
      chk("int_request", 16'h0, {15'h0, irq});
      pin(1'b0);
      chk("pin_level", 16'h1, {15'h0, lvl});
      pin(1'b1);
      chk("int_request", 16'h1, {15'h0, irq});
      @(posedge clk);
      vf <= 1'b1;
      @(posedge clk);
      vf <= 1'b0;
      #1;
      chk("int_request", 16'h0, {15'h0, irq});
      pin(1'b0);
   endtask
   task t_level;
      wr_reg(4'h0, 8'h01);
      pin(1'b1);
      wr_reg(4'h0, 8'h07);
      cyc(3);
      rd_chk(4'h0, 8'h0b);
      pin(1'b0);
      rd_chk(4'h0, 8'h03);
      wr_reg(4'h0, 8'h00);
   endtask
   task t_mask_break;
      wr_reg(4'h0, 8'h02);
      pin(1'b1);
      chk("int_request", 16'h0, {15'h0, irq});
      chk("wake_request", 16'h0, {15'h0, wake});
      wr_reg(4'h0, 8'h00);
      @(posedge clk);
      condition_code_register <= 1'b1;
      cyc(1);
      chk("int_request", 16'h0, {15'h0, irq});
      chk("wake_request", 16'h1, {15'h0, wake});
      @(posedge clk);
      condition_code_register <= 1'b0;
      brk <= 1'b1;
      wr_reg(4'h0, 8'h04);
      chk("int_request", 16'h1, {15'h0, irq});
      @(posedge clk);
      bce <= 1'b1;
      wr_reg(4'h0, 8'h04);
      @(posedge clk);
      brk <= 1'b0;
      cyc(2);
      chk("int_request", 16'h0, {15'h0, irq});
      pin(1'b0);
   endtask
   initial begin
      #200000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_edge();
      t_level();
      t_mask_break();
      complete_run();
   end
endmodule

// File: hw/eil_latch.sv
// External interrupt latch with status and control register
`timescale 1ns/1ps
`include "eil_params.svh"

module eil_latch (
   // Clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   resetn_i,
   // Register port
   input  wire logic [`EIL_ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]             reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output logic      [7:0]             reg_rdata_o,
   // External pin
   input  wire logic                   ext_int_n_i,
   // CPU side
   input  wire logic                   vector_fetch_i,
   input  wire logic                   ccr_int_mask_i,
   input  wire logic                   break_state_i,
   input  wire logic                   break_clear_enable_i,
   output logic                        int_request_o,
   output logic                        wake_request_o,
   output logic      [15:0]            vector_addr_hi_o,
   output logic      [15:0]            vector_addr_lo_o,
   output logic                        pin_level_o
);

   // ********************************
   // Pin synchroniser
   // ********************************
   logic               pin_meta_reg;
   logic               pin_sync_reg;
   logic               pin_prev_reg;
   logic               ext_int_mask_reg;
   logic               latch_reg;
   logic               ack_seen_reg;
   eil_pkg::eil_trig_type edge_level_select_reg;
   logic               sel_hit;
   logic               sw_ack;
   logic               ack;
   logic               fall_edge;
   logic               ack_blocked;

   // Reset image of the status and control register
   localparam logic [7:0] STATCTL_RST = `EIL_STATCTL_RST;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
         pin_prev_reg <= 1'b1;
      end else begin
         pin_meta_reg <= ext_int_n_i;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign fall_edge = pin_prev_reg && !pin_sync_reg;
   assign pin_level_o = pin_sync_reg;

   // ********************************
   // Register writes
   // ********************************
   assign sel_hit = (reg_addr_i == `EIL_STATCTL_OFS);
   assign sw_ack  = reg_wr_i && sel_hit && reg_wdata_i[`EIL_BIT_ACK]
                    && (!break_state_i || break_clear_enable_i);
   assign ack_blocked = reg_wr_i && sel_hit && reg_wdata_i[`EIL_BIT_ACK]
                        && break_state_i && !break_clear_enable_i;
   assign ack     = sw_ack || vector_fetch_i;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ext_int_mask_reg      <= STATCTL_RST[`EIL_BIT_MASK];
         edge_level_select_reg <= eil_pkg::eil_trig_type'(STATCTL_RST[`EIL_BIT_MODE]);
      end else if (reg_wr_i && sel_hit) begin
         ext_int_mask_reg      <= reg_wdata_i[`EIL_BIT_MASK];
         edge_level_select_reg <= eil_pkg::eil_trig_type'(reg_wdata_i[`EIL_BIT_MODE]);
      end
   end

   // ********************************
   // Request latch
   // ********************************
   // edge set wins; reset clear; clear persists
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         latch_reg    <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else if (fall_edge) begin
         latch_reg    <= 1'b1;
         ack_seen_reg <= 1'b0;
      end else if (edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY) begin
         if (ack) latch_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         // acknowledge and pin high, any order
         if ((ack || ack_seen_reg) && pin_sync_reg) begin
            latch_reg    <= 1'b0;
            ack_seen_reg <= 1'b0;
         end else begin
            if (!pin_sync_reg) latch_reg <= 1'b1;
            if (ack && latch_reg) ack_seen_reg <= 1'b1;
         end
      end
   end

   // ********************************
   // Request outputs
   // ********************************
   // mask gating
   assign int_request_o    = latch_reg && !ext_int_mask_reg && !ccr_int_mask_i;
   assign wake_request_o   = latch_reg && !ext_int_mask_reg;
   assign vector_addr_hi_o = `EIL_VECTOR_HI;
   assign vector_addr_lo_o = `EIL_VECTOR_LO;

   // ********************************
   // Register read
   // ********************************
   // readback
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i && sel_hit) begin
         reg_rdata_o <= 8'h00;
         reg_rdata_o[`EIL_BIT_FLAG] <= latch_reg;
         reg_rdata_o[`EIL_BIT_MASK] <= ext_int_mask_reg;
         reg_rdata_o[`EIL_BIT_MODE] <= edge_level_select_reg;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   edge_sets_a: assert property (fall_edge |=> latch_reg)
      else $error("Falling edge did not set latch");
   edge_ack_clr_a: assert property (!fall_edge && ack
         && edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY |=> !latch_reg)
      else $error("Edge mode acknowledge did not clear");
   level_hold_a: assert property (latch_reg && !pin_sync_reg && !fall_edge
         && edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL |=> latch_reg)
      else $error("Level mode cleared while pin low");
   mask_gate_a: assert property (ext_int_mask_reg || ccr_int_mask_i |-> !int_request_o)
      else $error("Masked request presented");
   unmask_req_a: assert property (latch_reg && !ext_int_mask_reg && !ccr_int_mask_i
         |-> int_request_o)
      else $error("Unmasked request withheld");
   break_block_a: assert property (break_state_i && !break_clear_enable_i && !ack_seen_reg
         && !vector_fetch_i && latch_reg |=> latch_reg)
      else $error("Acknowledge cleared latch in protected break");
   ack_reads_zero_a: assert property (1'b1 |-> !reg_rdata_o[`EIL_BIT_ACK])
      else $error("Acknowledge bit read as one");
   flag_read_a: assert property (reg_rd_i && sel_hit |=> reg_rdata_o[`EIL_BIT_FLAG]
         == $past(latch_reg))
      else $error("Event flag readback wrong");
   wake_a: assert property (latch_reg && !ext_int_mask_reg |-> wake_request_o)
      else $error("Wake not raised");

   edge_cov_c: cover property (fall_edge ##[1:5] ack);
   level_cov_c: cover property (edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL
         && ack && !pin_sync_reg ##[1:20] !latch_reg);
   break_cov_c: cover property (break_state_i && sw_ack && latch_reg);
   mask_cov_c: cover property (latch_reg && ext_int_mask_reg ##1 !ext_int_mask_reg);
   blocked_cov_c: cover property (ack_blocked && latch_reg);

   // ********************************
   // Pin path checks
   // ********************************
   // sync chain step
   sync_follow_a: assert property ($past(resetn_i)
         |-> pin_sync_reg == $past(pin_meta_reg))
      else $error("Sync stage out of step");

   pin_level_a: assert property ($past(resetn_i)
         |-> pin_level_o == $past(pin_meta_reg))
      else $error("Pin level not from sync stage");

   rise_cause_a: assert property ($rose(latch_reg)
         |-> $past(fall_edge)
         || $past(!pin_sync_reg && edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL))
      else $error("Latch set without cause");

   // ********************************
   // Latch checks
   // ********************************
   // fetch clears in edge mode
   fetch_clr_a: assert property (vector_fetch_i && !fall_edge
         && edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY |=> !latch_reg)
      else $error("Vector fetch did not clear");

   sw_clr_a: assert property (reg_wr_i && sel_hit && reg_wdata_i[`EIL_BIT_ACK]
         && !break_state_i && !fall_edge
         && edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY |=> !latch_reg)
      else $error("Acknowledge write did not clear");

   reset_clr_a: assert property (disable iff (1'b0) !resetn_i
         |=> !latch_reg && !ack_seen_reg)
      else $error("Reset left latch set");

   // recorded acknowledge clears at pin high
   level_clr_a: assert property (edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL
         && ack_seen_reg && pin_sync_reg && !fall_edge |=> !latch_reg)
      else $error("Level mode did not clear at pin high");

   ack_record_a: assert property (edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL
         && ack && latch_reg && !pin_sync_reg && !fall_edge |=> ack_seen_reg)
      else $error("Level mode acknowledge lost");

   level_set_a: assert property (edge_level_select_reg == eil_pkg::EIL_EDGE_LEVEL
         && !pin_sync_reg |=> latch_reg)
      else $error("Low level did not hold request");

   clr_stays_a: assert property (!latch_reg && !fall_edge
         && (edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY || pin_sync_reg)
         |=> !latch_reg)
      else $error("Cleared latch set again");

   break_refuse_a: assert property (ack_blocked && !vector_fetch_i
         && !ack_seen_reg && latch_reg |=> latch_reg)
      else $error("Refused acknowledge cleared latch");

   // ********************************
   // Register checks
   // ********************************
   // mask written from data
   mask_write_a: assert property (reg_wr_i && sel_hit
         |=> ext_int_mask_reg == $past(reg_wdata_i[`EIL_BIT_MASK]))
      else $error("Mask bit not written");

   mode_write_a: assert property (reg_wr_i && sel_hit
         |=> edge_level_select_reg == $past(reg_wdata_i[`EIL_BIT_MODE]))
      else $error("Mode bit not written");

   reg_reset_a: assert property (disable iff (1'b0) !resetn_i
         |=> !ext_int_mask_reg && edge_level_select_reg == eil_pkg::EIL_EDGE_ONLY)
      else $error("Reset left mask or mode set");

   rdata_idle_a: assert property ($past(resetn_i) && !$past(reg_rd_i && sel_hit)
         |-> reg_rdata_o == 8'h00)
      else $error("Read data not idle");

   mask_read_a: assert property (reg_rd_i && sel_hit
         |=> reg_rdata_o[`EIL_BIT_MASK] == $past(ext_int_mask_reg))
      else $error("Mask readback wrong");

   mode_read_a: assert property (reg_rd_i && sel_hit
         |=> reg_rdata_o[`EIL_BIT_MODE] == $past(edge_level_select_reg))
      else $error("Mode readback wrong");

   // ********************************
   // Request output checks
   // ********************************
   // mask blocks stop wake
   wake_mask_a: assert property (ext_int_mask_reg |-> !wake_request_o)
      else $error("Wake raised while masked");

   idle_quiet_a: assert property (!latch_reg |-> !int_request_o && !wake_request_o)
      else $error("Request raised without latch");

endmodule

// File: hw/eil_params.svh
// Register offsets, field positions and reset values for the external interrupt latch
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

`define EIL_ADDR_W        4
`define EIL_STATCTL_OFS   4'h0
`define EIL_BIT_MODE      0
`define EIL_BIT_MASK      1
`define EIL_BIT_ACK       2
`define EIL_BIT_FLAG      3
`define EIL_STATCTL_RST   8'h00
`define EIL_VECTOR_HI     16'hfffa
`define EIL_VECTOR_LO     16'hfffb

`endif

// File: hw/eil_pkg.sv
// Types shared by the external interrupt latch
package eil_pkg;
   typedef enum logic [0:0] {
      EIL_EDGE_ONLY  = 1'b0,
      EIL_EDGE_LEVEL = 1'b1
   } eil_trig_type;
endpackage
